/* File: sim/cpu_instruction_timing_decode_test.sv */
`default_nettype none
`define compare(got, exp) begin num_checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("wrong value at %0t ns: got %0h expected %0h", $time, got, exp); end end

module cpu_instruction_timing_decode_test;
    timeunit 1ns;
    timeprecision 1ps;
    import itd_pkg::*;

    logic        clock_i = 1'b0;
    logic        arst_n_i;
    logic        instr_valid_i;
    instr_s      instr_i;
    core_state_s st;
    logic        ready_o;
    logic        done_o;
    info_s       info_o;
    logic [15:0] pc;
    logic [1:0]  len;
    int          num_errors;
    int          num_checks;

    // Opcode, byte length and cycle count of the forms that never branch.
    localparam logic [15:0] fixed_tbl [0:32] = '{
        16'h6333, 16'hE411, 16'hF411, 16'h2311, 16'h3311, 16'h0311, 16'h1311,
        16'hC411, 16'h8533, 16'hE612, 16'h8622, 16'h9033, 16'h9313, 16'h8313,
        16'hE213, 16'hE013, 16'hD612, 16'hB222, 16'h8222, 16'hB022, 16'h7222,
        16'hA022, 16'hA222, 16'h9222, 16'hC311, 16'hD311, 16'hB311, 16'h0011,
        16'hA511, 16'hF213, 16'hF013, 16'hC022, 16'hD022};
    // Opcode, length, not-taken cycles and whether the first state takes it.
    localparam logic [19:0] branch_tbl [0:12] = '{
        20'h4_0221, 20'h5_0220, 20'h2_0331, 20'h3_0330, 20'h1_0331, 20'h6_0221,
        20'h7_0220, 20'hB_4331, 20'hB_5331, 20'hB_D331, 20'hB_6341, 20'hD_8221,
        20'hD_5331};

    ////////////////////////////////////////////////////////////////////////////
    itd_prog_model MEM (
        .pc_i    (pc),
        .len_i   (len),
        .instr_o (instr_i)
    );

    cpu_instruction_timing_decode #(.PROG_AW(13)) DUT (
        .clock_i       (clock_i),
        .arst_n_i      (arst_n_i),
        .instr_valid_i (instr_valid_i),
        .instr_i       (instr_i),
        .state_i       (st),
        .ready_o       (ready_o),
        .done_o        (done_o),
        .info_o        (info_o)
    );

    // Free-running 250 MHz clock.
    always #2 clock_i = ~clock_i;

    ////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("checks %0d, errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Offers one instruction at a falling edge and returns in its done cycle,
    // so the next call offers back to back. With hold set the valid stays up
    // while busy; a wrongly taken second offer would push done later.
    task automatic run(input logic [7:0] opc, b1, b2, input logic [15:0] at,
                       input logic [1:0] ln, input int cyc, input logic tk, input bit hold);
        int n;
        MEM.load(at, opc, b1, b2);
        pc = at;
        len = ln;
        instr_valid_i = 1'b1;
        @(posedge clock_i);
        @(negedge clock_i);
        instr_valid_i = hold;
        `compare(ready_o, cyc == 1)
        n = 1;
        while (done_o !== 1'b1 && n < 8) begin
            @(negedge clock_i);
            n++;
        end
        `compare(n, cyc)
        `compare(ready_o, 1'b1)
        `compare(info_o.len, ln)
        `compare(info_o.cycles, cyc[2:0])
        `compare(info_o.branch_taken, tk)
    endtask

    task automatic fixed_forms();
        for (int i = 0; i < 33; i++) begin
            run(fixed_tbl[i][15:8], 8'h45, 8'h67, 16'h0200 + 16'(i * 4),
                fixed_tbl[i][5:4], int'(fixed_tbl[i][3:0]), 1'b0, 1'b0);
            `compare(info_o.unsupported, 1'b0)
        end
        // An opcode outside this set is flagged, with one byte and one cycle.
        run(8'h28, 8'h00, 8'h00, 16'h0290, 2'h1, 1, 1'b0, 1'b0);
        `compare(info_o.unsupported, 1'b1)
    endtask

    // Both passes run every conditional form, the second with each condition
    // reversed and a backward displacement.
    task automatic branches();
        logic [19:0] e;
        logic        tk;
        logic [7:0]  rel;
        logic [15:0] at;
        for (int s = 0; s < 2; s++) begin
            st.carry = (s == 0);
            st.bit_value = (s == 0);
            st.acc = (s == 0) ? 8'h00 : 8'h05;
            st.cmp_lhs = 8'h11;
            st.cmp_rhs = (s == 0) ? 8'h22 : 8'h11;
            st.djnz_value = (s == 0) ? 8'h05 : 8'h01;
            rel = (s == 0) ? 8'h10 : 8'hF0;
            for (int i = 0; i < 13; i++) begin
                e = branch_tbl[i];
                tk = e[0] ^ (s == 1);
                at = 16'h0400 + 16'(i * 4);
                run(e[19:12], (e[9:8] == 2'h3) ? 8'h20 : rel, rel, at, e[9:8],
                    int'(e[7:4]) + int'(tk), tk, e[19:12] == 8'hB6);
                if (tk) begin
                    `compare(info_o.target, at + {14'h0, e[9:8]} + {{8{rel[7]}}, rel})
                end
                if (e[9:8] == 2'h3 && e[19:16] < 4'h4) begin
                    `compare(info_o.bit_byte_addr, 8'h24)
                end
                if (e[19:12] == 8'h10) begin
                    `compare(info_o.clear_bit, tk)
                end
            end
        end
    endtask

    task automatic operands();
        logic [2:0] n;
        st.r0 = 8'h3C;
        st.r1 = 8'h5A;
        for (int b = 0; b < 4; b++) begin
            n = 3'((b * 3) % 8);
            st.register_bank_select = 2'(b);
            run(8'hE8 | {5'h0, n}, 8'h00, 8'h00, 16'h0600, 2'h1, 1, 1'b0, 1'b0);
            `compare(info_o.bank_register_operand, 5'(b * 8) + {2'h0, n})
        end
        run(8'hE6, 8'h00, 8'h00, 16'h0610, 2'h1, 2, 1'b0, 1'b0);
        `compare(info_o.indirect_index_operand, 8'h3C)
        run(8'hE7, 8'h00, 8'h00, 16'h0614, 2'h1, 2, 1'b0, 1'b0);
        `compare(info_o.indirect_index_operand, 8'h5A)
        for (int d = 8'h7F; d < 8'h81; d++) begin
            run(8'hE5, 8'(d), 8'h00, 16'h0620, 2'h2, 2, 1'b0, 1'b0);
            `compare(info_o.direct_addr, 8'(d))
            `compare(info_o.direct_is_sfr, d == 8'h80)
        end
    endtask

    task automatic jump(input logic [7:0] opc, b1, b2, input logic [15:0] at,
                        input logic [1:0] ln, input int cyc, input logic [15:0] tgt);
        run(opc, b1, b2, at, ln, cyc, 1'b1, 1'b0);
        `compare(info_o.target_valid, 1'b1)
        `compare(info_o.target, tgt)
    endtask

    task automatic targets();
        st.acc = 8'h10;
        st.data_pointer = 16'h1000;
        jump(8'hE1, 8'h34, 8'h00, 16'h07FE, 2'h2, 3, 16'h0F34);
        jump(8'h11, 8'h34, 8'h00, 16'h1000, 2'h2, 3, 16'h1034);
        jump(8'h02, 8'hFF, 8'hFF, 16'h0300, 2'h3, 4, 16'h1FFF);
        jump(8'h12, 8'h12, 8'h34, 16'h0310, 2'h3, 4, 16'h1234);
        jump(8'h80, 8'hFE, 8'h00, 16'h0320, 2'h2, 3, 16'h0320);
        jump(8'h73, 8'h00, 8'h00, 16'h0330, 2'h1, 3, 16'h1010);
        run(8'h22, 8'h00, 8'h00, 16'h0340, 2'h1, 5, 1'b1, 1'b0);
        run(8'h32, 8'h00, 8'h00, 16'h0344, 2'h1, 5, 1'b1, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Reset is held eight cycles; the first offer waits out the reset synchroniser.
    initial begin
        arst_n_i = 1'b0;
        instr_valid_i = 1'b0;
        pc = 16'h0000;
        len = 2'h0;
        st = '0;
        num_errors = 0;
        num_checks = 0;
        repeat (8) @(negedge clock_i);
        arst_n_i = 1'b1;
        repeat (3) @(negedge clock_i);
        fixed_forms();
        branches();
        operands();
        targets();
        summarize();
    end

    // Some 76 instructions of at most five cycles fit well inside this span.
    initial begin
        #20000;
        num_errors++;
        summarize();
    end
endmodule
`default_nettype wire

/* File: sim/itd_prog_model.sv */
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Program memory in front of the decoder: it offers the opcode and the two bytes
// after it, plus the address of the following instruction.
module itd_prog_model (
    input  wire logic [15:0] pc_i,
    input  wire logic [1:0]  len_i,
    output itd_pkg::instr_s  instr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import itd_pkg::*;

    logic [7:0]  code_mem [0:8191];
    logic [12:0] addr0;
    logic [12:0] addr1;
    logic [12:0] addr2;

    // The whole three-byte window is always written, so bytes beyond an
    // instruction's length hold stale operands that the decoder must ignore.
    task automatic load(input logic [15:0] addr, input logic [7:0] b0, b1, b2);
        code_mem[addr[12:0]] = b0;
        code_mem[addr[12:0] + 13'h1] = b1;
        code_mem[addr[12:0] + 13'h2] = b2;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Fetch wraps inside the 8 kB space, as the program counter would.
    assign addr0   = pc_i[12:0];
    assign addr1   = pc_i[12:0] + 13'h1;
    assign addr2   = pc_i[12:0] + 13'h2;
    assign instr_o = {code_mem[addr0], code_mem[addr1], code_mem[addr2],
                      pc_i + {14'h0, len_i}};
endmodule
`default_nettype wire

/* File: src/cpu_instruction_timing_decode.sv */
`include "itd_cfg.svh"
`default_nettype none
module cpu_instruction_timing_decode #(
    parameter int PROG_AW = `ITD_PROG_AW
) (
    input  wire logic                 clock_i,
    input  wire logic                 arst_n_i,
    input  wire logic                 instr_valid_i,
    input  wire itd_pkg::instr_s      instr_i,
    input  wire itd_pkg::core_state_s state_i,
    output logic                      ready_o,
    output logic                      done_o,
    output itd_pkg::info_s            info_o
);
    import itd_pkg::*;

    // A page target needs more than the page bits, and addresses are 16 bits.
    if (PROG_AW <= `ITD_PAGE_LSB || PROG_AW > 16) begin : g_bad_aw
        $error("PROG_AW must lie between 12 and 16");
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset release.

    logic [1:0] rst_sync_q;
    logic       rst_n;

    // The asynchronous reset is released through two flops to avoid
    // recovery hazards on the sequencing logic.
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_sync_q <= `ITD_RST_SYNC;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    ////////////////////////////////////////////////////////////////////////
    // Functions.

    function automatic dec_s mk(input logic [1:0] len, input logic [2:0] cyc,
                                input logic cond, input branch_e br,
                                input target_e tg);
        dec_s d;
        d.len    = len;
        d.cycles = cyc;
        d.cond   = cond;
        d.branch = br;
        d.target = tg;
        d.known  = 1'b1;
        return d;
    endfunction

    // Length and base cycle count per opcode; for a conditional branch the
    // base is the not-taken count. Opcodes not listed are flagged unknown.
    function automatic dec_s decode(input logic [7:0] op);
        dec_s d;
        d = mk(2'd1, 3'd1, 1'b0, br_none, tgt_none);
        d.known = 1'b0;
        casez (op)
            `OP_XRL_DIR_IMM: d = mk(2'd3, 3'd3, 1'b0, br_none, tgt_none);
            8'h62, 8'h64, 8'h65: d = mk(2'd2, 3'd2, 1'b0, br_none, tgt_none);
            8'b0110_011?: d = mk(2'd1, 3'd2, 1'b0, br_none, tgt_none);
            8'b0110_1???: d = mk(2'd1, 3'd1, 1'b0, br_none, tgt_none);
            // Accumulator clear, complement, rotates and swap.
            8'hE4, 8'hF4, 8'h23, 8'h33,
            8'h03, 8'h13, 8'hC4: d = mk(2'd1, 3'd1, 1'b0, br_none, tgt_none);
            8'b1110_1???, 8'b1111_1???,
            8'b1100_1???: d = mk(2'd1, 3'd1, 1'b0, br_none, tgt_none);
            8'hE5, 8'h74, 8'hF5, 8'hC5: d = mk(2'd2, 3'd2, 1'b0, br_none, tgt_none);
            8'b1010_1???, 8'b0111_1???,
            8'b1000_1???: d = mk(2'd2, 3'd2, 1'b0, br_none, tgt_none);
            `OP_MOV_DIR_DIR, 8'h75: d = mk(2'd3, 3'd3, 1'b0, br_none, tgt_none);
            8'b1110_011?, 8'b1111_011?, 8'b1100_011?,
            8'b1101_011?: d = mk(2'd1, 3'd2, 1'b0, br_none, tgt_none);
            8'b1000_011?, 8'b1010_011?,
            8'b0111_011?: d = mk(2'd2, 3'd2, 1'b0, br_none, tgt_none);
            `OP_LOAD_POINTER: d = mk(2'd3, 3'd3, 1'b0, br_none, tgt_none);
            8'h93, 8'h83: d = mk(2'd1, 3'd3, 1'b0, br_none, tgt_none);
            // External reads and, following them, the writes.
            8'b1110_001?, 8'hE0,
            8'b1111_001?, 8'hF0: d = mk(2'd1, 3'd3, 1'b0, br_none, tgt_none);
            8'hC0, 8'hD0: d = mk(2'd2, 3'd2, 1'b0, br_none, tgt_none);
            8'hC3, 8'hD3, 8'hB3: d = mk(2'd1, 3'd1, 1'b0, br_none, tgt_none);
            8'hC2, 8'hD2, 8'hB2, 8'h82, 8'hB0, 8'h72,
            8'hA0, 8'hA2, 8'h92: d = mk(2'd2, 3'd2, 1'b0, br_none, tgt_none);
            `OP_JC: d = mk(2'd2, 3'd2, 1'b1, br_jc, tgt_rel1);
            8'h50: d = mk(2'd2, 3'd2, 1'b1, br_jnc, tgt_rel1);
            8'h20: d = mk(2'd3, 3'd3, 1'b1, br_jb, tgt_rel2);
            8'h30: d = mk(2'd3, 3'd3, 1'b1, br_jnb, tgt_rel2);
            `OP_JBC: d = mk(2'd3, 3'd3, 1'b1, br_jbc, tgt_rel2);
            8'b???1_0001: d = mk(2'd2, 3'd3, 1'b0, br_always, tgt_page);
            8'b???0_0001: d = mk(2'd2, 3'd3, 1'b0, br_always, tgt_page);
            8'h12, 8'h02: d = mk(2'd3, 3'd4, 1'b0, br_always, tgt_long);
            8'h22, 8'h32: d = mk(2'd1, 3'd5, 1'b0, br_always, tgt_none);
            `OP_SJMP: d = mk(2'd2, 3'd3, 1'b0, br_always, tgt_rel1);
            8'h73: d = mk(2'd1, 3'd3, 1'b0, br_always, tgt_acc_pointer);
            8'h60: d = mk(2'd2, 3'd2, 1'b1, br_jz, tgt_rel1);
            8'h70: d = mk(2'd2, 3'd2, 1'b1, br_jnz, tgt_rel1);
            8'hB4, 8'hB5,
            8'b1011_1???: d = mk(2'd3, 3'd3, 1'b1, br_cjne, tgt_rel2);
            8'b1011_011?: d = mk(2'd3, 3'd4, 1'b1, br_cjne, tgt_rel2);
            8'b1101_1???: d = mk(2'd2, 3'd2, 1'b1, br_djnz, tgt_rel1);
            8'hD5: d = mk(2'd3, 3'd3, 1'b1, br_djnz, tgt_rel2);
            `OP_NOP, `OP_SPARE: d = mk(2'd1, 3'd1, 1'b0, br_none, tgt_none);
            default: d.known = 1'b0;
        endcase
        return d;
    endfunction

    // Branch condition for the opcode's test against the core's state.
    function automatic logic taken_fn(input branch_e br, input core_state_s s);
        logic t;
        t = 1'b0;
        case (br)
            br_always: t = 1'b1;
            br_jc:     t = s.carry;
            br_jnc:    t = !s.carry;
            br_jb:     t = s.bit_value;
            br_jbc:    t = s.bit_value;
            br_jnb:    t = !s.bit_value;
            br_jz:     t = (s.acc == 8'h00);
            br_jnz:    t = (s.acc != 8'h00);
            br_cjne:   t = (s.cmp_lhs != s.cmp_rhs);
            br_djnz:   t = (s.djnz_value != 8'h01); // Value before the decrement.
            default:   t = 1'b0;
        endcase
        return t;
    endfunction

    // Signed displacement counted from the byte after the branch.
    function automatic logic [15:0] rel_fn(input logic [15:0] pc, input logic [7:0] disp);
        return pc + {{8{disp[7]}}, disp};
    endfunction

    // Byte holding a bit address: low half lives in the bit area of RAM,
    // upper half in the aligned special register.
    function automatic logic [7:0] bit_byte_fn(input logic [7:0] b);
        return b[7] ? {b[7:3], 3'h0} : (`ITD_BIT_AREA | {4'h0, b[6:3]});
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Decode of the presented instruction.

    localparam logic [15:0] LongMask = 16'((32'h1 << PROG_AW) - 32'h1);

    dec_s        dec_w;
    logic        accept_w;
    logic        taken_w;
    logic [2:0]  cycles_w;
    logic [15:0] page_w;
    logic [15:0] target_w;
    info_s       info_w;

    assign dec_w    = decode(instr_i.opcode);
    assign accept_w = instr_valid_i && ready_o;
    assign taken_w  = taken_fn(dec_w.branch, state_i);

    // A taken conditional branch costs one extra cycle.
    assign cycles_w = dec_w.cycles + {2'h0, dec_w.cond & taken_w};

    // Only the low eleven bits are replaced, so the jump never leaves the
    // page of the following instruction.
    assign page_w = {instr_i.next_pc[15:`ITD_PAGE_LSB], instr_i.opcode[7:5],
                     instr_i.op1};

    // Target selection; returns have no target known to this block.
    assign target_w =
        (dec_w.target == tgt_rel1)     ? rel_fn(instr_i.next_pc, instr_i.op1) :
        (dec_w.target == tgt_rel2)     ? rel_fn(instr_i.next_pc, instr_i.op2) :
        (dec_w.target == tgt_page)     ? page_w & LongMask :
        (dec_w.target == tgt_long)     ? {instr_i.op1, instr_i.op2} & LongMask :
        (dec_w.target == tgt_acc_pointer) ? state_i.data_pointer + {8'h00, state_i.acc} :
                                         16'h0000;

    // Operand addressing forms and timing, gathered for the result register.
    assign info_w.len                    = dec_w.len;
    assign info_w.cycles                 = cycles_w;
    assign info_w.branch_taken           = taken_w && (dec_w.branch != br_none);
    assign info_w.target_valid           = taken_w && (dec_w.target != tgt_none);
    assign info_w.target                 = target_w;
    assign info_w.direct_addr            = instr_i.op1;
    assign info_w.direct_is_sfr          = instr_i.op1[`ITD_SFR_BIT];
    assign info_w.bank_register_operand  = {state_i.register_bank_select,
                                            instr_i.opcode[2:0]};
    assign info_w.indirect_index_operand = instr_i.opcode[0] ? state_i.r1
                                                             : state_i.r0;
    assign info_w.bit_byte_addr          = bit_byte_fn(instr_i.op1);
    assign info_w.clear_bit              = (dec_w.branch == br_jbc) &&
                                           state_i.bit_value;
    assign info_w.unsupported            = !dec_w.known;

    ////////////////////////////////////////////////////////////////////////
    // Cycle sequencer.

    seq_state_e            state_q;
    seq_state_e            state_d;
    logic [`ITD_CNT_W-1:0] count_q;
    logic [`ITD_CNT_W-1:0] count_d;
    info_s                 info_q;

    // Next instruction may be offered in the final cycle of the current one,
    // so back-to-back streams keep the core fully busy.
    assign done_o  = (state_q == st_exec) && (count_q == 3'h1);
    assign ready_o = (state_q == st_idle) || done_o;
    assign info_o  = info_q;

    // The counter loads the cycle count and walks down to the final cycle.
    always_comb begin
        state_d = state_q;
        count_d = count_q;
        unique case (state_q)
            st_idle: begin
                if (accept_w) begin
                    state_d = st_exec;
                    count_d = cycles_w;
                end
            end
            st_exec: begin
                if (accept_w) begin
                    count_d = cycles_w;
                end else if (done_o) begin
                    state_d = st_idle;
                    count_d = 3'h0;
                end else begin
                    count_d = count_q - 3'h1;
                end
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= st_idle;
            count_q <= 3'h0;
            info_q  <= '0;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
            if (accept_w) begin
                info_q <= info_w;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n);

    property p_xrl_imm;
        accept_w && instr_i.opcode == `OP_XRL_DIR_IMM |=>
            info_o.len == 2'd3 && info_o.cycles == 3'd3;
    endproperty
    a_xrl_imm: assert property (p_xrl_imm) else $error("xor imm timing");

    property p_acc_one;
        accept_w && instr_i.opcode inside {8'hE4, 8'hF4, 8'h23, 8'hC4} |=> done_o;
    endproperty
    a_acc_one: assert property (p_acc_one) else $error("acc op not 1 cycle");

    property p_dir_dir;
        accept_w && instr_i.opcode == `OP_MOV_DIR_DIR |=> !done_o [*2] ##1 done_o;
    endproperty
    a_dir_dir: assert property (p_dir_dir) else $error("dir move timing");

    property p_jc_taken;
        accept_w && instr_i.opcode == `OP_JC |=>
            info_o.cycles == (3'd2 + {2'h0, $past(state_i.carry)});
    endproperty
    a_jc_taken: assert property (p_jc_taken) else $error("jc cycles");

    property p_jbc_clear;
        accept_w && instr_i.opcode == `OP_JBC |=> info_o.clear_bit == $past(state_i.bit_value);
    endproperty
    a_jbc_clear: assert property (p_jbc_clear) else $error("jbc clear");

    property p_sjmp_rel;
        accept_w && instr_i.opcode == `OP_SJMP |=>
            info_o.target == $past(instr_i.next_pc) + {{8{$past(instr_i.op1[7])}},
                                                        $past(instr_i.op1)};
    endproperty
    a_sjmp_rel: assert property (p_sjmp_rel) else $error("rel target");

    property p_page;
        accept_w && instr_i.opcode[3:0] == 4'h1 |=>
            info_o.target[12:11] == $past(instr_i.next_pc[12:11]);
    endproperty
    a_page: assert property (p_page) else $error("page left");

    property p_spare_nop;
        accept_w && instr_i.opcode == `OP_SPARE |=>
            info_o.cycles == 3'd1 && !info_o.unsupported ##0 done_o;
    endproperty
    a_spare_nop: assert property (p_spare_nop) else $error("spare opcode");

    property p_bank;
        accept_w |=> info_o.bank_register_operand[4:3] ==
                     $past(state_i.register_bank_select);
    endproperty
    a_bank: assert property (p_bank) else $error("bank map");

    property p_sfr;
        accept_w |=> info_o.direct_is_sfr == ($past(instr_i.op1) >= 8'h80);
    endproperty
    a_sfr: assert property (p_sfr) else $error("space select");

    // Two-cycle low-nibble exchange through an index register.
    property p_xchd;
        accept_w && instr_i.opcode[7:1] == 7'h6B |=> !done_o ##1 done_o;
    endproperty
    a_xchd: assert property (p_xchd) else $error("nibble exchange timing");

    // The accumulator is added unsigned to the pointer.
    property p_ptr_jump;
        accept_w && instr_i.opcode == 8'h73 |=>
            info_o.target == $past(state_i.data_pointer) + {8'h00, $past(state_i.acc)};
    endproperty
    a_ptr_jump: assert property (p_ptr_jump) else $error("ptr jump target");

    // Long targets take both operand bytes, high byte first.
    property p_long_target;
        accept_w && instr_i.opcode inside {8'h02, 8'h12} |=>
            info_o.target == ({$past(instr_i.op1), $past(instr_i.op2)} & LongMask) &&
            info_o.cycles == 3'd4;
    endproperty
    a_long_target: assert property (p_long_target) else $error("long target");

    // The indirect compare costs one cycle more than the other forms.
    property p_cjne_ind;
        accept_w && instr_i.opcode[7:1] == 7'h5B |=>
            info_o.cycles == 3'd4 + {2'h0, $past(state_i.cmp_lhs != state_i.cmp_rhs)};
    endproperty
    a_cjne_ind: assert property (p_cjne_ind) else $error("indirect compare cycles");

    // Only the first two bank registers serve as index registers.
    property p_indirect;
        accept_w |=> info_o.indirect_index_operand ==
                     ($past(instr_i.opcode[0]) ? $past(state_i.r1) : $past(state_i.r0));
    endproperty
    a_indirect: assert property (p_indirect) else $error("index register");

    // Main scenarios: back-to-back offers, slow compare, bit clear, carry jump, page call.
    c_b2b: cover property (done_o && accept_w);
    c_cjne5: cover property (accept_w && instr_i.opcode == 8'hB6 && taken_w);
    c_jbc: cover property (accept_w && info_w.clear_bit);
    c_jc_taken: cover property (accept_w && instr_i.opcode == `OP_JC && taken_w);
    c_page_call: cover property (accept_w && instr_i.opcode == 8'h11);

endmodule
`default_nettype wire

/* File: src/itd_cfg.svh */
// Overview of operation
// - XOR immediate into direct: 3 bytes, 3 cycles.
// - Accumulator single operations take one cycle.
// - Direct to direct move: 3 bytes, 3 cycles.
// - Accumulator load via index: 1 byte, 2 cycles.
// - Indirect to direct move: 2 bytes, 2 cycles.
// - Data pointer load: 3 bytes, 3 cycles.
// - Code byte reads: 1 byte, 3 cycles.
// - External data reads: 1 byte, 3 cycles.
// - Low nibble exchange: 1 byte, 2 cycles.
// - Bit and carry ops: 2/2; carry-only one.
// - Carry jumps: 2 bytes, 2 or 3 cycles.
// - Bit jumps 3/4 cycles; test-and-clear clears bit.
// - Accumulator plus pointer jump: 1 byte, 3 cycles.
// - Compare jumps 3/4, indirect form 4/5 cycles.
// - Decrement jumps: register 2/3, direct 3/4.
// - Register and indirect operands use active bank.
// - Relative displacement signed, from next instruction.
// - Direct below 0x80 is RAM, else special.
// - Page target keeps upper next-address bits.
// - Long target reaches whole program space.
// - Opcode 0xA5 behaves exactly like no-operation.
// - Not taken uses lower count, taken higher.
// - Bank select picks eight-byte register group.
`ifndef ITD_CFG_SVH
`define ITD_CFG_SVH

`define ITD_PROG_AW      13
`define ITD_PAGE_LSB     11
`define ITD_SFR_BIT      7
`define ITD_BIT_AREA     8'h20
`define ITD_CNT_W        3
`define ITD_RST_SYNC     2'h0

`define OP_NOP           8'h00
`define OP_SPARE         8'hA5
`define OP_XRL_DIR_IMM   8'h63
`define OP_MOV_DIR_DIR   8'h85
`define OP_LOAD_POINTER  8'h90
`define OP_JC            8'h40
`define OP_JBC           8'h10
`define OP_SJMP          8'h80

`endif

/* File: src/itd_pkg.sv */
`default_nettype none
package itd_pkg;

    typedef enum logic [3:0] {
        br_none = 4'h0, br_always = 4'h1, br_jc = 4'h2, br_jnc = 4'h3,
        br_jb = 4'h4, br_jnb = 4'h5, br_jbc = 4'h6, br_jz = 4'h7,
        br_jnz = 4'h8, br_cjne = 4'h9, br_djnz = 4'hA
    } branch_e;

    typedef enum logic [2:0] {
        tgt_none = 3'h0, tgt_rel1 = 3'h1, tgt_rel2 = 3'h2,
        tgt_page = 3'h3, tgt_long = 3'h4, tgt_acc_pointer = 3'h5
    } target_e;

    typedef enum logic [0:0] {st_idle = 1'h0, st_exec = 1'h1} seq_state_e;

    typedef struct packed {
        logic [1:0] len;
        logic [2:0] cycles;
        logic       cond;
        branch_e    branch;
        target_e    target;
        logic       known;
    } dec_s;

    typedef struct packed {
        logic [7:0]  opcode;
        logic [7:0]  op1;
        logic [7:0]  op2;
        logic [15:0] next_pc;
    } instr_s;

    typedef struct packed {
        logic [7:0]  acc;
        logic        carry;
        logic [1:0]  register_bank_select;
        logic [7:0]  r0;
        logic [7:0]  r1;
        logic [15:0] data_pointer;
        logic        bit_value;
        logic [7:0]  cmp_lhs;
        logic [7:0]  cmp_rhs;
        logic [7:0]  djnz_value;
    } core_state_s;

    typedef struct packed {
        logic [1:0]  len;
        logic [2:0]  cycles;
        logic        branch_taken;
        logic        target_valid;
        logic [15:0] target;
        logic [7:0]  direct_addr;
        logic        direct_is_sfr;
        logic [4:0]  bank_register_operand;
        logic [7:0]  indirect_index_operand;
        logic [7:0]  bit_byte_addr;
        logic        clear_bit;
        logic        unsupported;
    } info_s;

endpackage
`default_nettype wire
